// ===== distance_switch_regs.vh
`ifndef DISTANCE_SWITCH_REGS_VH
`define DISTANCE_SWITCH_REGS_VH
// Distance width in sensor units, delay width in ticks.
`define DIST_W 16
`define DLY_W 16
// Timer tick period in microseconds and derived clock cycles at 50 MHz.
`define CLK_MHZ 50
`define TICK_US 1000
`define TICK_CYCLES (`TICK_US * `CLK_MHZ)
`define TICK_CNT_W 16
// Last count of the tick divider, one less than the tick period in cycles.
`define TICK_LAST 16'hC34F
// Switch modes.
`define MODE_SETPOINT 1'b0
`define MODE_WINDOW 1'b1
// Forced-state actions: hold, on, off.
`define ACT_HOLD 2'h0
`define ACT_ON 2'h1
`define ACT_OFF 2'h2
// Driver types.
`define DRV_OFF 2'h0
`define DRV_SINK 2'h1
`define DRV_SOURCE 2'h2
// Activation modes.
`define ACTV_CONT 2'h0
`define ACTV_POLL 2'h1
`define ACTV_MASTER 2'h2
`define ACTV_SLAVE 2'h3
`endif

// ===== switch_channel.v
`timescale 1ns/1ps
`include "distance_switch_regs.vh"
module switch_channel (
  // Clock and reset.
  input  wire                core_clk,
  input  wire                reset,
  // Shared timing and events.
  input  wire                tick,
  input  wire                measDone,
  input  wire                targetValid,
  input  wire [`DIST_W-1:0]  distance,
  input  wire                syncLost,
  // Settings.
  input  wire                mode,
  input  wire                onFarther,
  input  wire                windowOnInside,
  input  wire [`DIST_W-1:0]  setpoint,
  input  wire [`DIST_W-1:0]  hysteresis,
  input  wire [`DIST_W-1:0]  windowFar,
  input  wire [`DLY_W-1:0]   onDelay,
  input  wire [`DLY_W-1:0]   offDelay,
  input  wire                powerUpOn,
  input  wire [1:0]          noTargetAct,
  input  wire                noTargetDlyEn,
  input  wire [`DLY_W-1:0]   noTargetDelay,
  input  wire [1:0]          noSyncAct,
  // Result.
  output reg                 switchOn_q
);
  reg               started_q;
  reg [`DLY_W-1:0]  qualCnt_q;
  reg [`DLY_W-1:0]  lostCnt_q;
  reg               wantOn;
  reg               inWin;
  reg [`DIST_W:0]   offThr;
  wire [`DLY_W-1:0] needDly = wantOn ? onDelay : offDelay;
  wire              lostTimed = !noTargetDlyEn || (lostCnt_q >= noTargetDelay);
  wire              qualDone = (qualCnt_q >= needDly);

  ////////////////////////////////////////////////////////////////////////////
  // Condition for the switch to be on from the present distance.
  always @* begin
    inWin = (distance >= setpoint) && (distance <= windowFar);
    offThr = {1'b0, setpoint};
    wantOn = switchOn_q;
    if (mode == `MODE_WINDOW) begin
      wantOn = inWin ? windowOnInside : !windowOnInside; // RULE_05 RULE_06 RULE_20
    end else if (!onFarther) begin
      offThr = {1'b0, setpoint} + {1'b0, hysteresis}; // RULE_04
      if (!switchOn_q) wantOn = (distance <= setpoint); // RULE_01 RULE_03
      else wantOn = ({1'b0, distance} < offThr); // RULE_02
    end else begin
      offThr = (hysteresis > setpoint) ? {(`DIST_W+1){1'b0}} : {1'b0, setpoint - hysteresis}; // RULE_04
      if (!switchOn_q) wantOn = (distance >= setpoint); // RULE_03
      else wantOn = ({1'b0, distance} > offThr); // RULE_02
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State update at each measurement end, on a slave sync loss and before the first measurement.
  always @(posedge core_clk) begin
    if (reset) begin
      switchOn_q <= 1'b0;
      started_q  <= 1'b0;
      qualCnt_q  <= {`DLY_W{1'b0}};
      lostCnt_q  <= {`DLY_W{1'b0}};
    end else begin
      if (measDone) started_q <= 1'b1;
      if (tick && targetValid) lostCnt_q <= {`DLY_W{1'b0}}; // RULE_21
      else if (tick && lostCnt_q != {`DLY_W{1'b1}}) lostCnt_q <= lostCnt_q + 1'b1; // RULE_09
      // A valid target must keep asking for the new state at every tick, or the delay restarts.
      if (tick && targetValid && wantOn != switchOn_q) begin
        if (qualCnt_q != {`DLY_W{1'b1}}) qualCnt_q <= qualCnt_q + 1'b1; // RULE_10
      end else if (tick) begin
        qualCnt_q <= {`DLY_W{1'b0}}; // RULE_21
      end
      // The first measurement ends the power-up state and is evaluated at once.
      if (syncLost && started_q) begin
        if (noSyncAct == `ACT_ON) switchOn_q <= 1'b1; // RULE_11
        else if (noSyncAct == `ACT_OFF) switchOn_q <= 1'b0;
      end else if (measDone) begin // RULE_19
        if (!targetValid) begin
          qualCnt_q <= {`DLY_W{1'b0}};
          if (lostTimed && noTargetAct == `ACT_ON) switchOn_q <= 1'b1; // RULE_08
          else if (lostTimed && noTargetAct == `ACT_OFF) switchOn_q <= 1'b0;
        end else if (wantOn == switchOn_q) begin
          qualCnt_q <= {`DLY_W{1'b0}}; // RULE_21
        end else if (qualDone) begin
          switchOn_q <= wantOn; // RULE_10
          qualCnt_q  <= {`DLY_W{1'b0}};
        end
      end else if (!started_q) begin
        switchOn_q <= powerUpOn; // RULE_07
      end
    end
  end
endmodule

// ===== distance_switch_logic.v
`timescale 1ns/1ps
`include "distance_switch_regs.vh"
// Function
// RULE_01: Setpoint mode turns on at setpoint.
// RULE_02: Turn off only past hysteresis band.
// RULE_03: Polarity selects on nearer or farther.
// RULE_04: Inverted polarity flips hysteresis direction.
// RULE_05: Window mode: in-window state versus opposite.
// RULE_06: Window far boundary and in-state configurable.
// RULE_07: Power-up state held until first measurement.
// RULE_08: No-target action: hold, on, off.
// RULE_09: No-target action after continuous absence delay.
// RULE_10: On/off delays need continuous qualification.
// RULE_11: Slave lost sync applies action after delay.
// RULE_12: One shared lost-sync delay for all outputs.
// RULE_13: Lost-sync actions only in slave mode.
// RULE_14: Targets nearer than minimum range invalid.
// RULE_15: Targets beyond maximum range count absent.
// RULE_16: Two independent switch outputs.
// RULE_17: Driver sinking, sourcing or disabled.
// RULE_18: Indicator follows switch unless reassigned.
// RULE_19: Switches update only at measurement end; a slave lost-sync action is applied on any clock after the first measurement end.
// RULE_20: Window near boundary is the setpoint.
// RULE_21: Delay timers use common tick, restart.
module distance_switch_logic (
  // Clock and reset.
  input  wire                 core_clk,
  input  wire                 reset,
  // Measurement engine results.
  input  wire                 measDone,
  input  wire                 targetSeen,
  input  wire [`DIST_W-1:0]   distance,
  input  wire                 syncPulse,
  // Shared settings.
  input  wire [1:0]           activationMode,
  input  wire [`DIST_W-1:0]   rangeMin,
  input  wire [`DIST_W-1:0]   rangeMax,
  input  wire [`DLY_W-1:0]    noSyncDelay,
  // Per-switch settings, switch 1 in the low slice.
  input  wire [1:0]           swMode,
  input  wire [1:0]           swOnFarther,
  input  wire [1:0]           swWindowOnInside,
  input  wire [2*`DIST_W-1:0] swSetpoint,
  input  wire [2*`DIST_W-1:0] swHysteresis,
  input  wire [2*`DIST_W-1:0] swWindowFar,
  input  wire [2*`DLY_W-1:0]  swOnDelay,
  input  wire [2*`DLY_W-1:0]  swOffDelay,
  input  wire [1:0]           swPowerUpOn,
  input  wire [3:0]           swNoTargetAct,
  input  wire [1:0]           swNoTargetDlyEn,
  input  wire [2*`DLY_W-1:0]  swNoTargetDelay,
  input  wire [3:0]           swNoSyncAct,
  input  wire [3:0]           swDriverType,
  input  wire [1:0]           swIndicatorReassign,
  input  wire [1:0]           swIndicatorAlt,
  // Outputs.
  output wire [1:0]           switchState,
  output reg  [1:0]           sinkDrive_q,
  output reg  [1:0]           sourceDrive_q,
  output reg  [1:0]           indicatorOn_q,
  output wire                 syncLost
);
  reg [`TICK_CNT_W-1:0] tickCnt_q;
  reg                   tick_q;
  reg [`DLY_W-1:0]      syncCnt_q;
  wire                  isSlave = (activationMode == `ACTV_SLAVE);
  wire                  targetValid;

  ////////////////////////////////////////////////////////////////////////////
  // Common time tick for every delay timer.
  always @(posedge core_clk) begin
    if (reset) begin
      tickCnt_q <= {`TICK_CNT_W{1'b0}};
      tick_q    <= 1'b0;
    end else if (tickCnt_q == `TICK_LAST) begin
      tickCnt_q <= {`TICK_CNT_W{1'b0}}; // RULE_21
      tick_q    <= 1'b1;
    end else begin
      tickCnt_q <= tickCnt_q + 1'b1;
      tick_q    <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Range gating of the measured distance.
  assign targetValid = targetSeen && (distance >= rangeMin) && (distance <= rangeMax); // RULE_14 RULE_15

  ////////////////////////////////////////////////////////////////////////////
  // Lost synchronisation detection, slave mode only.
  always @(posedge core_clk) begin
    if (reset || !isSlave || syncPulse) begin
      syncCnt_q <= {`DLY_W{1'b0}};
    end else if (tick_q && syncCnt_q != {`DLY_W{1'b1}}) begin
      syncCnt_q <= syncCnt_q + 1'b1;
    end
  end
  assign syncLost = isSlave && !syncPulse && (syncCnt_q >= noSyncDelay); // RULE_11 RULE_12 RULE_13

  ////////////////////////////////////////////////////////////////////////////
  // Two independent switch channels.
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : chan
      switch_channel u_chan ( // RULE_16
        .core_clk       (core_clk),
        .reset          (reset),
        .tick           (tick_q),
        .measDone       (measDone),
        .targetValid    (targetValid),
        .distance       (distance),
        .syncLost       (syncLost),
        .mode           (swMode[i]),
        .onFarther      (swOnFarther[i]),
        .windowOnInside (swWindowOnInside[i]),
        .setpoint       (swSetpoint[i*`DIST_W +: `DIST_W]),
        .hysteresis     (swHysteresis[i*`DIST_W +: `DIST_W]),
        .windowFar      (swWindowFar[i*`DIST_W +: `DIST_W]),
        .onDelay        (swOnDelay[i*`DLY_W +: `DLY_W]),
        .offDelay       (swOffDelay[i*`DLY_W +: `DLY_W]),
        .powerUpOn      (swPowerUpOn[i]),
        .noTargetAct    (swNoTargetAct[2*i +: 2]),
        .noTargetDlyEn  (swNoTargetDlyEn[i]),
        .noTargetDelay  (swNoTargetDelay[i*`DLY_W +: `DLY_W]),
        .noSyncAct      (swNoSyncAct[2*i +: 2]),
        .switchOn_q     (switchState[i])
      );

      // Output driver and rear indicator.
      always @(posedge core_clk) begin
        if (reset) begin
          sinkDrive_q[i]   <= 1'b0;
          sourceDrive_q[i] <= 1'b0;
          indicatorOn_q[i] <= 1'b0;
        end else begin
          sinkDrive_q[i]   <= switchState[i] && (swDriverType[2*i +: 2] == `DRV_SINK); // RULE_17
          sourceDrive_q[i] <= switchState[i] && (swDriverType[2*i +: 2] == `DRV_SOURCE); // RULE_17
          indicatorOn_q[i] <= swIndicatorReassign[i] ? swIndicatorAlt[i] : switchState[i]; // RULE_18
        end
      end
    end
  endgenerate
endmodule

// ===== distance_switch_checker_assertions.sv
`timescale 1ns/1ps
`include "distance_switch_regs.vh"
module distance_switch_checker (
  // Clock and reset.
  input wire       core_clk,
  input wire       reset,
  // Watched inputs.
  input wire       measDone,
  input wire [1:0] activationMode,
  input wire [1:0] swPowerUpOn,
  input wire [3:0] swNoSyncAct,
  input wire [3:0] swDriverType,
  input wire [1:0] swIndicatorReassign,
  input wire [1:0] swIndicatorAlt,
  // Watched outputs.
  input wire [1:0] switchState,
  input wire [1:0] sinkDrive_q,
  input wire [1:0] sourceDrive_q,
  input wire [1:0] indicatorOn_q,
  input wire       syncLost
);
  // The power-up state has priority over a sync loss until a measurement has ended.
  reg measSeen_q;
  always @(posedge core_clk) begin
    if (reset) begin
      measSeen_q <= 1'b0;
    end else if (measDone) begin
      measSeen_q <= 1'b1;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence s_lostOn;
    measSeen_q && syncLost && swNoSyncAct[1:0] == `ACT_ON;
  endsequence
  property p_powerUp;
    $fell(reset) && !measDone |=> switchState == swPowerUpOn;
  endproperty
  a_powerUp: assert property (p_powerUp) else $error("power-up state missing");
  property p_hold;
    !measDone && !syncLost && !$fell(reset) |=> $stable(switchState);
  endproperty
  a_hold: assert property (p_hold) else $error("switch changed between measurements");
  property p_sink;
    switchState[0] && swDriverType[1:0] == `DRV_SINK |=> sinkDrive_q[0] && !sourceDrive_q[0];
  endproperty
  a_sink: assert property (p_sink) else $error("sinking drive wrong");
  property p_source;
    switchState[1] && swDriverType[3:2] == `DRV_SOURCE |=> sourceDrive_q[1] && !sinkDrive_q[1];
  endproperty
  a_source: assert property (p_source) else $error("sourcing drive wrong");
  property p_indicator;
    !swIndicatorReassign[0] |=> indicatorOn_q[0] == $past(switchState[0]);
  endproperty
  a_indicator: assert property (p_indicator) else $error("indicator not following switch");
  property p_indicatorAlt;
    swIndicatorReassign[1] |=> indicatorOn_q[1] == $past(swIndicatorAlt[1]);
  endproperty
  a_indicatorAlt: assert property (p_indicatorAlt) else $error("reassigned indicator wrong");
  property p_syncGate;
    activationMode != `ACTV_SLAVE |-> !syncLost;
  endproperty
  a_syncGate: assert property (p_syncGate) else $error("sync loss outside slave mode");
  property p_lostAct;
    s_lostOn |=> switchState[0];
  endproperty
  a_lostAct: assert property (p_lostAct) else $error("sync loss action not applied");
endmodule
bind distance_switch_logic distance_switch_checker distance_switch_checker_inst (
  .core_clk(core_clk), .reset(reset), .measDone(measDone), .activationMode(activationMode),
  .swPowerUpOn(swPowerUpOn), .swNoSyncAct(swNoSyncAct), .swDriverType(swDriverType),
  .swIndicatorReassign(swIndicatorReassign), .swIndicatorAlt(swIndicatorAlt),
  .switchState(switchState), .sinkDrive_q(sinkDrive_q), .sourceDrive_q(sourceDrive_q),
  .indicatorOn_q(indicatorOn_q), .syncLost(syncLost)
);

// ===== switch_load.sv
`timescale 1ns/1ps
module switch_load (
  // Switch drives.
  input  wire [1:0] sinkDrive,
  input  wire [1:0] sourceDrive,
  // Load state.
  output wire [1:0] loadOn
);
  // Either a sinking or a sourcing switch energises the load.
  assign loadOn = sinkDrive | sourceDrive;
endmodule

// ===== distance_switch_logic_test.sv
`timescale 1ns/1ps
module distance_switch_logic_test;
  reg        core_clk = 1'b0, reset = 1'b1, measDone = 1'b0, targetSeen = 1'b0, syncPulse = 1'b0;
  reg [1:0]  activationMode = 2'h0, swMode = 2'h0, swOnFarther = 2'h2, swWindowOnInside = 2'h1;
  reg [1:0]  swPowerUpOn = 2'h2, swNoTargetDlyEn = 2'h0, swIndicatorReassign = 2'h2, swIndicatorAlt = 2'h2;
  reg [15:0] distance = 16'h0000, rangeMin = 16'h0032, rangeMax = 16'h012C, noSyncDelay = 16'h0000;
  reg [31:0] swSetpoint = 32'h00640064, swHysteresis = 32'h00140014, swWindowFar = 32'h00C800C8;
  reg [31:0] swOnDelay = 32'h0, swOffDelay = 32'h0, swNoTargetDelay = 32'h0;
  reg [3:0]  swNoTargetAct = 4'h9, swNoSyncAct = 4'h9, swDriverType = 4'h9;
  wire [1:0] switchState, sinkDrive_q, sourceDrive_q, indicatorOn_q, loadOn;
  wire       syncLost;
  integer    miscompares = 0, compares = 0;
  distance_switch_logic distance_switch_logic_inst (
    .core_clk(core_clk), .reset(reset), .measDone(measDone), .targetSeen(targetSeen),
    .distance(distance), .syncPulse(syncPulse), .activationMode(activationMode), .rangeMin(rangeMin),
    .rangeMax(rangeMax), .noSyncDelay(noSyncDelay), .swMode(swMode), .swOnFarther(swOnFarther),
    .swWindowOnInside(swWindowOnInside), .swSetpoint(swSetpoint), .swHysteresis(swHysteresis),
    .swWindowFar(swWindowFar), .swOnDelay(swOnDelay), .swOffDelay(swOffDelay),
    .swPowerUpOn(swPowerUpOn), .swNoTargetAct(swNoTargetAct), .swNoTargetDlyEn(swNoTargetDlyEn),
    .swNoTargetDelay(swNoTargetDelay), .swNoSyncAct(swNoSyncAct), .swDriverType(swDriverType),
    .swIndicatorReassign(swIndicatorReassign), .swIndicatorAlt(swIndicatorAlt),
    .switchState(switchState), .sinkDrive_q(sinkDrive_q), .sourceDrive_q(sourceDrive_q),
    .indicatorOn_q(indicatorOn_q), .syncLost(syncLost));
  switch_load switch_load_inst (.sinkDrive(sinkDrive_q), .sourceDrive(sourceDrive_q), .loadOn(loadOn));
  initial forever #10 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////
  task chk(input [1:0] got, input [1:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("mismatch at %0t: got %b expected %b", $time, got, exp);
    end
  endtask
  // One measurement result, then the switch states one edge later.
  task meas(input [15:0] d, input seen, input [1:0] exp);
    @(posedge core_clk) #1;
    measDone = 1'b1;
    distance = d;
    targetSeen = seen;
    @(posedge core_clk) #1;
    measDone = 1'b0;
    chk(switchState, exp);
  endtask
  task do_reset;
    reset = 1'b1;
    repeat (2) @(posedge core_clk);
    #1 reset = 1'b0;
    @(posedge core_clk) #1;
    chk(switchState, swPowerUpOn);
    $display("test power-up done");
  endtask
  task test_done;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  task test_setpoint;
    meas(16'h005A, 1'b1, 2'h3);
    meas(16'h006E, 1'b1, 2'h3);
    meas(16'h007D, 1'b1, 2'h2);
    meas(16'h0050, 1'b1, 2'h1);
    meas(16'h0069, 1'b1, 2'h3);
    @(posedge core_clk) #1;
    chk(loadOn, 2'h3);
    swDriverType = 4'h8;
    @(posedge core_clk) #1;
    chk(loadOn, 2'h2);
    chk(indicatorOn_q, 2'h3);
    swDriverType = 4'h9;
    $display("test setpoint done");
  endtask
  task test_window;
    swMode = 2'h3;
    meas(16'h0096, 1'b1, 2'h1);
    meas(16'h00FA, 1'b1, 2'h2);
    meas(16'h0064, 1'b1, 2'h1);
    meas(16'h00C8, 1'b1, 2'h1);
    meas(16'h0063, 1'b1, 2'h2);
    $display("test window done");
  endtask
  task test_no_target;
    meas(16'h0096, 1'b0, 2'h1);
    swNoTargetAct = 4'h6;
    meas(16'h0190, 1'b1, 2'h2);
    meas(16'h0096, 1'b1, 2'h1);
    meas(16'h0028, 1'b1, 2'h2);
    swNoTargetAct = 4'h0;
    meas(16'h0096, 1'b1, 2'h1);
    meas(16'h0000, 1'b0, 2'h1);
    swNoTargetDlyEn = 2'h3;
    swNoTargetDelay = 32'h00010001;
    swNoTargetAct = 4'h6;
    meas(16'h0000, 1'b0, 2'h1);
    swNoTargetDlyEn = 2'h0;
    swNoTargetAct = 4'h0;
    $display("test no target done");
  endtask
  // Switch 1 gets a one tick turn-on delay; the wait covers at least one full tick.
  task test_delay;
    swMode = 2'h0;
    meas(16'h0082, 1'b1, 2'h2);
    swOnDelay = 32'h00000001;
    meas(16'h005A, 1'b1, 2'h2);
    repeat (60000) @(posedge core_clk);
    meas(16'h005A, 1'b1, 2'h3);
    swOnDelay = 32'h0;
    $display("test delay done");
  endtask
  task test_sync;
    activationMode = 2'h3;
    syncPulse = 1'b1;
    meas(16'h0082, 1'b1, 2'h2);
    chk({1'b0, syncLost}, 2'h0);
    syncPulse = 1'b0;
    @(posedge core_clk) #1;
    chk({1'b0, syncLost}, 2'h1);
    chk(switchState, 2'h1);
    meas(16'h0082, 1'b1, 2'h1);
    activationMode = 2'h0;
    @(posedge core_clk) #1;
    chk({1'b0, syncLost}, 2'h0);
    meas(16'h0082, 1'b1, 2'h2);
    $display("test sync done");
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    do_reset;
    test_setpoint;
    test_window;
    test_no_target;
    test_delay;
    do_reset;
    test_sync;
    test_done;
  end
  initial begin
    #2000000;
    miscompares = miscompares + 1;
    test_done;
  end
endmodule
